// ### shared/ord_bus_cfg.svh
`ifndef ORD_BUS_CFG_SVH
`define ORD_BUS_CFG_SVH
// Area numbering and counts
`define AREA_CNT 5
`define AREA_FOUR 3'h4
`define AREA_TWO 3'h2
`define AREA_THREE 3'h3
// Access size and port width codes (shared encoding)
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
// Per-area delay field codes
`define DLY_NONE 2'h0
`define DLY_ONE 2'h1
`define DLY_TWO 2'h2
`define DLY_LONG 2'h3
// Setup/hold limits
`define SH_MAX 2'h2
`define A4_HOLD_C0 3'h0
`define A4_HOLD_C1 3'h1
`define A4_HOLD_C2 3'h3
`define A4_HOLD_C3 3'h5
// Area 4 extra release states (total delay minus the second state)
`define REL_EXTRA_1 2'h0
`define REL_EXTRA_2 2'h1
`define REL_EXTRA_4 2'h3
// Synchronous DRAM area select codes
`define SD_SEL_A3 3'h1
`define SD_SEL_A2 3'h4
`define SD_SEL_BOTH 3'h5
// Burst lengths
`define BURST_NARROW 4'h8
`define BURST_WIDE 4'h4
// Reset values
`define RST_LANES_N 4'hF
`define RST_AREAS_N 5'h1F
`define RST_WORD 32'h00000000
`endif

// ### shared/ord_bus_pkg.sv
package ord_bus_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_FIRST = 6'h04,
    ST_DELAY = 6'h08,
    ST_SECOND = 6'h10,
    ST_HOLD = 6'h20
  } bus_state_t;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_REF = 4'h1,
    CMD_SELF = 4'h2,
    CMD_PALL = 4'h3,
    CMD_PRE = 4'h4,
    CMD_ACTV = 4'h5,
    CMD_READ = 4'h6,
    CMD_READA = 4'h7,
    CMD_WRIT = 4'h8,
    CMD_WRITA = 4'h9,
    CMD_MRS = 4'hA
  } sdram_cmd_t;

  // Ordinary access request
  typedef struct packed {
    logic [2:0] area;
    logic [24:0] addr;
    logic [1:0] size;
    logic write;
    logic [31:0] wdata;
  } bus_req_t;

  // Static configuration
  typedef struct packed {
    logic [4:0][1:0] area_delay_field;
    logic [4:0][1:0] port_width;
    logic [2:0] long_delay_0;
    logic [2:0] long_delay_1;
    logic [2:0] shared_long_delay_field;
    logic [2:0] long_delay_4;
    logic [4:0] hold_off_mask_bit;
    logic [1:0] area4_release_delay_field;
    logic [3:0][1:0] setup_hold_count_field;
    logic [2:0] area4_setup_count_field;
    logic [1:0] area4_hold_count_field;
    logic [2:0] sdram_area_select;
    logic sdram_width_bit;
    logic burst_write_select;
    logic burst_enable_ignored;
    logic ratio_one;
  } bus_cfg_t;

  // Synchronous DRAM command from the sequencer
  typedef struct packed {
    sdram_cmd_t cmd;
    logic [1:0] area_sel;
    logic [1:0] addr;
    logic [1:0] size;
  } sdram_req_t;
endpackage : ord_bus_pkg

// ### core/byte_lane_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "ord_bus_cfg.svh"
module byte_lane_sel
  import ord_bus_pkg::*;
(
  input wire logic [1:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] width_i,
  output logic [3:0] lane_o
);
  // Lane 3 is the lowest address on a wide port, lane 0 the highest
  always_comb
  begin
    lane_o = 4'h0;
    case (width_i)
      `SZ_LONG:
      begin
        case (size_i)
          `SZ_BYTE: lane_o = 4'h8 >> addr_i;
          `SZ_WORD: lane_o = addr_i[1] ? 4'h3 : 4'hC;
          default: lane_o = 4'hF;
        endcase
      end
      `SZ_WORD:
      begin
        if (size_i == `SZ_BYTE)
          lane_o = addr_i[0] ? 4'h1 : 4'h2;
        else
          lane_o = 4'h3;
      end
      default: lane_o = 4'h1;
    endcase
  end
endmodule : byte_lane_sel
`default_nettype wire

// ### core/wait_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "ord_bus_cfg.svh"
module wait_decode
  import ord_bus_pkg::*;
(
  input wire bus_cfg_t cfg_i,
  input wire logic [2:0] area_i,
  output logic [3:0] delay_cnt_o,
  output logic hold_off_en_o,
  output logic [2:0] setup_cnt_o,
  output logic [2:0] hold_cnt_o,
  output logic [1:0] rel_extra_o
);
  logic [1:0] fld;
  logic [2:0] lng;
  // Delay count from the area field or its long field
  always_comb
  begin
    fld = cfg_i.area_delay_field[area_i];
    case (area_i)
      3'h0: lng = cfg_i.long_delay_0;
      3'h1: lng = cfg_i.long_delay_1;
      `AREA_FOUR: lng = cfg_i.long_delay_4;
      default: lng = cfg_i.shared_long_delay_field;
    endcase
    case (fld)
      `DLY_LONG: delay_cnt_o = {lng, 1'b0};
      default: delay_cnt_o = {2'h0, fld};
    endcase
    hold_off_en_o = (fld != `DLY_NONE) && !cfg_i.hold_off_mask_bit[area_i];
  end

  // Setup, hold and release counts
  always_comb
  begin
    setup_cnt_o = 3'h0;
    hold_cnt_o = 3'h0;
    rel_extra_o = `REL_EXTRA_1;
    if (area_i == `AREA_FOUR)
    begin
      setup_cnt_o = cfg_i.area4_setup_count_field;
      case (cfg_i.area4_hold_count_field)
        2'h0: hold_cnt_o = `A4_HOLD_C0;
        2'h1: hold_cnt_o = `A4_HOLD_C1;
        2'h2: hold_cnt_o = `A4_HOLD_C2;
        default: hold_cnt_o = `A4_HOLD_C3;
      endcase
      case (cfg_i.area4_release_delay_field)
        2'h0: rel_extra_o = `REL_EXTRA_1;
        2'h1: rel_extra_o = `REL_EXTRA_2;
        default: rel_extra_o = `REL_EXTRA_4;
      endcase
    end
    else
    begin
      setup_cnt_o = {1'b0, cfg_i.setup_hold_count_field[area_i[1:0]]};
      if (setup_cnt_o > {1'b0, `SH_MAX})
        setup_cnt_o = {1'b0, `SH_MAX};
      hold_cnt_o = setup_cnt_o;
    end
  end
endmodule : wait_decode
`default_nettype wire

// ### core/ord_sdram_bus.sv
`timescale 1ns/1ps
`default_nettype none
`include "ord_bus_cfg.svh"
module ord_sdram_bus
  import ord_bus_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire bus_cfg_t cfg_i,
  input wire logic req_valid_i,
  input wire bus_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  input wire logic hold_off_n_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe_o,
  output logic [24:0] addr_o,
  output logic bus_cycle_start_strobe_n_o,
  output logic [4:0] chip_select_strobe_n_o,
  output logic cs_mid_negate_o,
  output logic read_strobe_n_o,
  output logic [3:0] byte_write_strobe_n_o,
  output logic rd_wr_n_o,
  input wire sdram_req_t sd_req_i,
  output logic [1:0] sdram_area_o,
  output logic sdram_burst_write_o,
  output logic [3:0] sdram_burst_len_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic cmd_a10_o,
  output logic clock_enable_o,
  output logic [3:0] byte_mask_n_o
);
  bus_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic rel_q, rel_d;
  logic [1:0] part_q, part_d, last_q, last_d;
  bus_req_t r_q, r_d;
  logic [31:0] rdata_d, data_d;
  logic done_d, bs_d, rd_d, oe_d, dir_d, mid_d;
  logic [4:0] cs_d;
  logic [3:0] we_d, lane, eff_lane, sd_lane;
  logic [1:0] pw, pw_sz, eff_sz, sd_w;
  logic [3:0] dly_cnt;
  logic hold_en;
  logic [2:0] su_cnt, ho_cnt;
  logic [1:0] rel_x;
  logic [1:0] sd_area_d;
  logic ras_d, cas_d, sdwe_d, a10_d, cke_d;
  logic [24:0] step;
  logic [2:0] su_cnt_next;

  // Decode of the latched area
  wait_decode u_wait (
    .cfg_i(cfg_i),
    .area_i(r_q.area),
    .delay_cnt_o(dly_cnt),
    .hold_off_en_o(hold_en),
    .setup_cnt_o(su_cnt),
    .hold_cnt_o(ho_cnt),
    .rel_extra_o(rel_x)
  );

  // Byte strobes for the part being driven next
  byte_lane_sel u_lane (
    .addr_i(r_d.addr[1:0]),
    .size_i(eff_sz),
    .width_i(pw_sz),
    .lane_o(eff_lane)
  );

  // DRAM byte masks
  byte_lane_sel u_mask (
    .addr_i(sd_req_i.addr),
    .size_i(sd_req_i.size),
    .width_i(sd_w),
    .lane_o(sd_lane)
  );

  assign sd_w = cfg_i.sdram_width_bit ? `SZ_LONG : `SZ_WORD;
  assign sd_area_d[0] = (cfg_i.sdram_area_select == `SD_SEL_A2) ||
    (cfg_i.sdram_area_select == `SD_SEL_BOTH);
  assign sd_area_d[1] = (cfg_i.sdram_area_select == `SD_SEL_A3) ||
    (cfg_i.sdram_area_select == `SD_SEL_BOTH);

  // Access sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rel_d = rel_q;
    part_d = part_q;
    last_d = last_q;
    r_d = r_q;
    done_d = 1'b0;
    rdata_d = rdata_o;
    pw = cfg_i.port_width[req_i.area];
    step = (r_q.size == `SZ_LONG && cfg_i.port_width[r_q.area] == `SZ_WORD) ?
      25'h0000002 : 25'h0000001;
    case (state_q)
      ST_IDLE:
      begin
        if (req_valid_i && req_ready_o && !((req_i.area == `AREA_TWO && sd_area_d[0]) ||
            (req_i.area == `AREA_THREE && sd_area_d[1])))
        begin
          r_d = req_i;
          part_d = 2'h0;
          rel_d = 1'b0;
          cnt_d = {1'b0, su_cnt_next} - 4'h1;
          // Number of port-width parts minus one
          if (pw == `SZ_BYTE && req_i.size == `SZ_LONG)
            last_d = 2'h3;
          else if (pw != `SZ_LONG && req_i.size != `SZ_BYTE && req_i.size != pw)
            last_d = 2'h1;
          else
            last_d = 2'h0;
          // Split parts shift the data to the port's low lanes
          if (last_d != 2'h0)
            r_d.wdata = (req_i.size == `SZ_WORD) ? {req_i.wdata[15:0], 16'h0000} :
              req_i.wdata;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (cnt_q == 4'h0)
          state_d = ST_FIRST;
        else
          cnt_d = cnt_q - 4'h1;
      end
      ST_FIRST:
      begin
        if (dly_cnt != 4'h0)
        begin
          state_d = ST_DELAY;
          cnt_d = dly_cnt - 4'h1;
        end
        else
          state_d = ST_SECOND;
      end
      ST_DELAY:
      begin
        if (cnt_q != 4'h0)
          cnt_d = cnt_q - 4'h1;
        else if (rel_q)
          state_d = ST_SECOND;
        else if (hold_en && !hold_off_n_i)
          state_d = ST_DELAY;
        else if (hold_en && r_q.area == `AREA_FOUR && rel_x != `REL_EXTRA_1)
        begin
          rel_d = 1'b1;
          cnt_d = {2'h0, rel_x} - 4'h1;
        end
        else
          state_d = ST_SECOND;
      end
      ST_SECOND:
      begin
        rel_d = 1'b0;
        case (cfg_i.port_width[r_q.area])
          `SZ_BYTE: rdata_d = {rdata_o[23:0], data_i[7:0]};
          `SZ_WORD: rdata_d = (last_q == 2'h0) ? data_i : {rdata_o[15:0], data_i[15:0]};
          default: rdata_d = data_i;
        endcase
        if (part_q != last_q)
        begin
          part_d = part_q + 2'h1;
          r_d.addr = r_q.addr + step;
          r_d.wdata = (step == 25'h0000002) ? {r_q.wdata[15:0], 16'h0000} :
            {r_q.wdata[23:0], 8'h00};
          state_d = ST_FIRST;
        end
        else if (ho_cnt != 3'h0)
        begin
          state_d = ST_HOLD;
          cnt_d = {1'b0, ho_cnt} - 4'h1;
        end
        else
        begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_HOLD:
      begin
        if (cnt_q == 4'h0)
        begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      default: state_d = ST_IDLE;
    endcase
    // Setup entry skips straight to the first state when no setup is set
    if (state_q == ST_IDLE && state_d == ST_SETUP && su_cnt_next == 3'h0)
      state_d = ST_FIRST;
  end

  // Pin values for the state being entered
  always_comb
  begin
    pw_sz = cfg_i.port_width[r_d.area];
    eff_sz = (last_d != 2'h0) ? pw_sz : r_d.size;
    bs_d = !(state_d == ST_FIRST);
    cs_d = `RST_AREAS_N;
    if (state_d != ST_IDLE)
      cs_d[r_d.area] = 1'b0;
    mid_d = (state_d == ST_SECOND) && !(cfg_i.ratio_one && part_d != last_d);
    rd_d = !(!r_d.write && (state_d == ST_FIRST || state_d == ST_DELAY ||
      state_d == ST_SECOND));
    lane = (r_d.write && (state_d == ST_FIRST || state_d == ST_DELAY ||
      state_d == ST_SECOND)) ? eff_lane : 4'h0;
    we_d = ~lane;
    oe_d = r_d.write && (state_d != ST_IDLE);
    data_d = (last_d == 2'h0) ? r_d.wdata :
      ((pw_sz == `SZ_BYTE) ? {24'h000000, r_d.wdata[31:24]} :
      {16'h0000, r_d.wdata[31:16]});
    dir_d = !(r_d.write && state_d != ST_IDLE);
    // Command encode: row, column, write, address line ten, clock enable
    {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h1D;
    case (sd_req_i.cmd)
      CMD_REF: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h03;
      CMD_SELF: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h02;
      CMD_PALL: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h0B;
      CMD_PRE: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h09;
      CMD_ACTV: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h0D;
      CMD_READ: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h15;
      CMD_READA: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h17;
      CMD_WRIT: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h11;
      CMD_WRITA: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h13;
      CMD_MRS: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h01;
      default: {ras_d, cas_d, sdwe_d, a10_d, cke_d} = 5'h1D;
    endcase
    // Shared pins; each memory acts only under its own select
    if (sd_req_i.cmd != CMD_NOP)
      dir_d = sdwe_d;
    cs_d[`AREA_TWO] = cs_d[`AREA_TWO] & !(sd_req_i.area_sel[0] && sd_area_d[0]);
    cs_d[`AREA_THREE] = cs_d[`AREA_THREE] & !(sd_req_i.area_sel[1] && sd_area_d[1]);
  end

  // Registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rel_q <= 1'b0;
      part_q <= 2'h0;
      last_q <= 2'h0;
      r_q <= '0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= `RST_WORD;
      data_o <= `RST_WORD;
      data_oe_o <= 1'b0;
      addr_o <= 25'h0000000;
      bus_cycle_start_strobe_n_o <= 1'b1;
      chip_select_strobe_n_o <= `RST_AREAS_N;
      cs_mid_negate_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      byte_write_strobe_n_o <= `RST_LANES_N;
      rd_wr_n_o <= 1'b1;
      sdram_area_o <= 2'h0;
      sdram_burst_write_o <= 1'b0;
      sdram_burst_len_o <= `BURST_NARROW;
      row_strobe_n_o <= 1'b1;
      col_strobe_n_o <= 1'b1;
      cmd_a10_o <= 1'b0;
      clock_enable_o <= 1'b1;
      byte_mask_n_o <= `RST_LANES_N;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rel_q <= rel_d;
      part_q <= part_d;
      last_q <= last_d;
      r_q <= r_d;
      req_ready_o <= (state_d == ST_IDLE);
      done_o <= done_d;
      rdata_o <= rdata_d;
      data_o <= data_d;
      data_oe_o <= oe_d;
      addr_o <= r_d.addr;
      bus_cycle_start_strobe_n_o <= bs_d;
      chip_select_strobe_n_o <= cs_d;
      cs_mid_negate_o <= mid_d;
      read_strobe_n_o <= rd_d;
      byte_write_strobe_n_o <= we_d;
      rd_wr_n_o <= dir_d;
      sdram_area_o <= sd_area_d;
      sdram_burst_write_o <= cfg_i.burst_write_select;
      sdram_burst_len_o <= cfg_i.sdram_width_bit ? `BURST_WIDE : `BURST_NARROW;
      row_strobe_n_o <= ras_d;
      col_strobe_n_o <= cas_d;
      cmd_a10_o <= a10_d;
      clock_enable_o <= cke_d;
      byte_mask_n_o <= ~(sd_req_i.cmd == CMD_NOP ? 4'hF : sd_lane);
    end
  end

  // Setup count of the area being accepted
  wait_decode u_wait_new (
    .cfg_i(cfg_i),
    .area_i(req_i.area),
    .delay_cnt_o(),
    .hold_off_en_o(),
    .setup_cnt_o(su_cnt_next),
    .hold_cnt_o(),
    .rel_extra_o()
  );

  // Checks
  sequence s_first_then_second;
    state_q == ST_FIRST ##1 state_q == ST_SECOND;
  endsequence
  property p_bs_one_cycle;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(bus_cycle_start_strobe_n_o) |=> bus_cycle_start_strobe_n_o;
  endproperty
  a_bs_one_cycle: assert property (p_bs_one_cycle) else $error("start strobe too long");
  property p_no_wait_two;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_FIRST && dly_cnt == 4'h0) |-> s_first_then_second;
  endproperty
  a_no_wait_two: assert property (p_no_wait_two) else $error("zero-wait not two cycles");
  property p_dir_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_IDLE && $past(sd_req_i.cmd) == CMD_NOP) |-> rd_wr_n_o;
  endproperty
  a_dir_idle: assert property (p_dir_idle) else $error("direction not read when idle");
  property p_idle_strobes;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_SETUP || state_q == ST_HOLD) |->
      (read_strobe_n_o && byte_write_strobe_n_o == `RST_LANES_N && !(&chip_select_strobe_n_o));
  endproperty
  a_idle_strobes: assert property (p_idle_strobes) else $error("strobe in setup or hold");
  property p_read_no_we;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q != ST_IDLE && !r_q.write) |-> byte_write_strobe_n_o == `RST_LANES_N;
  endproperty
  a_read_no_we: assert property (p_read_no_we) else $error("write strobe on read");
  property p_masked_no_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_DELAY && cnt_q == 4'h0 && !hold_en && !rel_q) |=> state_q == ST_SECOND;
  endproperty
  a_masked_no_hold: assert property (p_masked_no_hold) else $error("masked hold-off stalled");
  property p_hold_stall;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_DELAY && cnt_q == 4'h0 && hold_en && !rel_q && !hold_off_n_i) |=>
      (state_q == ST_DELAY && !read_strobe_n_o == !r_q.write);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("hold-off not honoured");
  property p_cke_self;
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 (clock_enable_o == ($past(sd_req_i.cmd) != CMD_SELF));
  endproperty
  a_cke_self: assert property (p_cke_self) else $error("clock enable wrong");
  property p_burst_len;
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 (sdram_burst_len_o == ($past(cfg_i.sdram_width_bit) ? `BURST_WIDE : `BURST_NARROW));
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
  property p_sd_sel;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!$past(rst_i) && $past(cfg_i.sdram_area_select) == `SD_SEL_BOTH) |-> sdram_area_o == 2'h3;
  endproperty
  a_sd_sel: assert property (p_sd_sel) else $error("area select decode wrong");
endmodule : ord_sdram_bus
`default_nettype wire

// ### testbench/sram_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sram_partner
  import ord_bus_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic read_strobe_n_i,
  input wire logic [24:0] addr_i,
  input wire logic [3:0] hold_cycles_i,
  output logic hold_off_n_o,
  output logic [31:0] data_o
);
  logic [31:0] last_q = 32'h0;
  logic [3:0] cnt_q = 4'h0;
  logic hold_q = 1'b1;
  // Address-tagged data while read, inverted last value once released
  always_comb data_o = !read_strobe_n_i ? {8'hA5, addr_i[7:0], 8'h5A, addr_i[7:0]} : ~last_q;
  assign hold_off_n_o = hold_q;
  // Hold-off low for a set count of read cycles, changed at rising edge
  always @(posedge clk_sys_i)
  begin
    if (!read_strobe_n_i) last_q <= data_o;
    cnt_q <= read_strobe_n_i ? 4'h0 : cnt_q + 4'h1;
    hold_q <= read_strobe_n_i ? 1'b1 : (cnt_q >= hold_cycles_i);
  end
endmodule : sram_partner
`default_nettype wire

// ### testbench/test_ord_sdram_bus.sv
`timescale 1ns/1ps
`default_nettype none
`include "ord_bus_cfg.svh"
module test_ord_sdram_bus
  import ord_bus_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  bus_cfg_t cfg_i = '0;
  logic req_valid_i = 1'b0;
  bus_req_t req_i = '0;
  sdram_req_t sd_req_i = '0;
  logic req_ready_o, done_o, hold_off_n_i, bus_cycle_start_strobe_n_o, read_strobe_n_o;
  logic rd_wr_n_o, sdram_burst_write_o, row_strobe_n_o, col_strobe_n_o, cmd_a10_o;
  logic clock_enable_o, cs_mid_negate_o, data_oe_o;
  logic [31:0] rdata_o, data_i, data_o, data_seen;
  logic [24:0] addr_o, addr_seen;
  logic [4:0] chip_select_strobe_n_o, cs_seen;
  logic [3:0] byte_write_strobe_n_o, byte_mask_n_o, sdram_burst_len_o, we_seen;
  logic [3:0] hold_cycles = 4'h0;
  logic [1:0] sdram_area_o;
  int fail_count = 0;
  int samples_checked = 0;
  int bs_cnt, cyc, mid_cnt, oe_cnt;
  logic [4:0] enc [11] = '{5'h1D, 5'h03, 5'h02, 5'h0B, 5'h09, 5'h0D, 5'h15, 5'h17,
    5'h11, 5'h13, 5'h01};
  always #2 clk_sys_i = ~clk_sys_i;
  ord_sdram_bus i_dut (.clk_sys_i, .rst_i, .cfg_i, .req_valid_i, .req_i, .req_ready_o,
    .done_o, .rdata_o, .hold_off_n_i, .data_i, .data_o, .data_oe_o, .addr_o,
    .bus_cycle_start_strobe_n_o, .chip_select_strobe_n_o, .cs_mid_negate_o,
    .read_strobe_n_o, .byte_write_strobe_n_o, .rd_wr_n_o, .sd_req_i, .sdram_area_o,
    .sdram_burst_write_o, .sdram_burst_len_o, .row_strobe_n_o, .col_strobe_n_o,
    .cmd_a10_o, .clock_enable_o, .byte_mask_n_o);
  sram_partner i_mem (.clk_sys_i, .read_strobe_n_i(read_strobe_n_o), .addr_i(addr_o),
    .hold_cycles_i(hold_cycles), .hold_off_n_o(hold_off_n_i), .data_o(data_i));
  // Collect start strobes, address and strobes seen during an access
  always @(posedge clk_sys_i)
  begin
    if (!bus_cycle_start_strobe_n_o) bs_cnt++;
    if (!bus_cycle_start_strobe_n_o) addr_seen = addr_o;
    we_seen &= byte_write_strobe_n_o;
    cs_seen &= chip_select_strobe_n_o;
    if (cs_mid_negate_o) mid_cnt++;
    if (data_oe_o) oe_cnt++;
    if (data_oe_o) data_seen = data_o;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One ordinary access, cycles counted from the taking edge to done
  task automatic access(input logic [2:0] a, input logic [24:0] ad, input logic [1:0] sz,
    input logic w);
    bs_cnt = 0;
    mid_cnt = 0;
    oe_cnt = 0;
    we_seen = 4'hF;
    cs_seen = 5'h1F;
    cyc = 0;
    while (req_ready_o !== 1'b1) @(negedge clk_sys_i);
    req_i = '{a, ad, sz, w, 32'h11223344};
    req_valid_i = 1'b1;
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && cyc < 60)
    begin
      @(negedge clk_sys_i);
      cyc++;
    end
    if (done_o !== 1'b1) fail_count++;
    @(negedge clk_sys_i);
  endtask : access
  task automatic sd(input sdram_cmd_t c, input logic [4:0] e);
    sd_req_i.cmd = c;
    repeat (2) @(negedge clk_sys_i);
    check({row_strobe_n_o, col_strobe_n_o, rd_wr_n_o, cmd_a10_o, clock_enable_o}, e);
  endtask : sd
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end
  initial
  begin
    cfg_i.port_width = {5{`SZ_LONG}};
    repeat (4) @(negedge clk_sys_i);
    check(chip_select_strobe_n_o, 5'h1F);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check(clock_enable_o, 1'b1);
    check(sdram_burst_len_o, `BURST_NARROW);
    $display("reset test done");
    access(3'h0, 25'h12, `SZ_WORD, 1'b0);
    check(cyc, 2);
    check(bs_cnt, 1);
    check(mid_cnt, 1);
    check(rdata_o, 32'hA5125A12);
    check(addr_seen, 25'h12);
    check(cs_seen, 5'h1E);
    check(rd_wr_n_o, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      access(3'h1, 25'(i), `SZ_BYTE, 1'b1);
      check(we_seen, 4'(~(4'h8 >> i)));
    end
    cfg_i.port_width[2] = `SZ_BYTE;
    access(3'h2, 25'h1, `SZ_BYTE, 1'b1);
    check(we_seen, 4'hE);
    access(3'h2, 25'h200, `SZ_LONG, 1'b0);
    check(bs_cnt, 4);
    check(rdata_o, 32'h00010203);
    check(mid_cnt, 4);
    cfg_i.port_width[1] = `SZ_WORD;
    cfg_i.ratio_one = 1'b1;
    access(3'h1, 25'h100, `SZ_LONG, 1'b0);
    check(bs_cnt, 2);
    check(rdata_o, 32'h5A005A02);
    check(mid_cnt, 1);
    $display("lane and split test done");
    cfg_i.long_delay_0 = 3'h3;
    for (int i = 1; i < 4; i++)
    begin
      cfg_i.area_delay_field[0] = 2'(i);
      access(3'h0, 25'h4, `SZ_LONG, 1'b0);
      check(cyc, (i == 3) ? 8 : 2 + i);
    end
    cfg_i.area_delay_field[3] = `DLY_LONG;
    cfg_i.shared_long_delay_field = 3'h1;
    access(3'h3, 25'h4, `SZ_LONG, 1'b0);
    check(cyc, 4);
    cfg_i.area_delay_field[4] = `DLY_LONG;
    cfg_i.long_delay_4 = 3'h2;
    access(3'h4, 25'h4, `SZ_LONG, 1'b0);
    check(cyc, 6);
    hold_cycles = 4'h5;
    cfg_i.area_delay_field[0] = `DLY_ONE;
    access(3'h0, 25'h8, `SZ_LONG, 1'b0);
    check(cyc, 8);
    cfg_i.hold_off_mask_bit[0] = 1'b1;
    access(3'h0, 25'h8, `SZ_LONG, 1'b0);
    check(cyc, 3);
    cfg_i.area_delay_field[1] = `DLY_NONE;
    access(3'h1, 25'h8, `SZ_WORD, 1'b0);
    check(cyc, 2);
    hold_cycles = 4'h0;
    $display("delay test done");
    cfg_i.hold_off_mask_bit[0] = 1'b0;
    cfg_i.area_delay_field[0] = `DLY_NONE;
    cfg_i.setup_hold_count_field[0] = 2'h2;
    access(3'h0, 25'h0, `SZ_LONG, 1'b1);
    check(cyc, 6);
    check(oe_cnt, 6);
    check(data_seen, 32'h11223344);
    cfg_i.area_delay_field[4] = `DLY_NONE;
    cfg_i.area4_setup_count_field = 3'h3;
    cfg_i.area4_hold_count_field = 2'h3;
    access(3'h4, 25'h0, `SZ_LONG, 1'b1);
    check(cyc, 10);
    check(cs_seen, 5'h0F);
    $display("setup hold test done");
    for (int i = 0; i < 4; i++)
    begin
      cfg_i.sdram_area_select = (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : (i == 2) ? 3'h4 : 3'h5;
      repeat (2) @(negedge clk_sys_i);
      check(sdram_area_o, (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : 2'h3);
    end
    sd_req_i.area_sel = 2'h1;
    for (int i = 0; i < 11; i++) sd(sdram_cmd_t'(4'(i)), enc[i]);
    cfg_i.sdram_width_bit = 1'b1;
    cfg_i.burst_write_select = 1'b1;
    sd_req_i.addr = 2'h3;
    sd(CMD_READ, enc[6]);
    check(byte_mask_n_o, 4'hE);
    check(sdram_burst_len_o, `BURST_WIDE);
    check(sdram_burst_write_o, 1'b1);
    cfg_i.sdram_width_bit = 1'b0;
    sd_req_i.addr = 2'h0;
    sd(CMD_READ, enc[6]);
    check(byte_mask_n_o, 4'hD);
    $display("sdram test done");
    summarize();
  end
endmodule : test_ord_sdram_bus
`default_nettype wire
